// File: shared/psp_defs.svh
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH

// ============================================================
// Register map (byte addresses)
`define PSP_REG_STATUS      8'h00
`define PSP_REG_CTRL        8'h04
`define PSP_REG_STRAP       8'h08

// ============================================================
// Field positions
`define PSP_CTRL_LED_EN     0
`define PSP_STAT_ADDR_LSB   0
`define PSP_STAT_MODE       5
`define PSP_STAT_LINK       6
`define PSP_STAT_SPEED      7
`define PSP_STAT_DUPLEX     8
`define PSP_STAT_CARRIER    9
`define PSP_STAT_COLL       10
`define PSP_STAT_LEVEL_LSB  16

// ============================================================
// Reset values and codes
`define PSP_CTRL_RESET      1'b1
`define PSP_SFD_PATTERN     8'hab
`define PSP_RESP_OKAY       2'b00
`define PSP_RESP_SLVERR     2'b10

// ============================================================
// Timing: 250 MHz core clock, RMII 50 MHz dibit slot
`define PSP_CLK_MHZ         250
`define PSP_RMII_MHZ        50
`define PSP_DIV_100M        (`PSP_CLK_MHZ / `PSP_RMII_MHZ)
`define PSP_DIV_10M         (`PSP_DIV_100M * 10)

`endif

// File: shared/psp_pkg.sv
`include "psp_defs.svh"

package psp_pkg;

    typedef enum logic [0:0] {
        PSP_PH_RESET = 1'b0,
        PSP_PH_RUN   = 1'b1
    } psp_phase_t;

    typedef enum logic [1:0] {
        PSP_RX_IDLE = 2'b00,
        PSP_RX_HUNT = 2'b01,
        PSP_RX_PASS = 2'b10
    } psp_rx_t;

    typedef struct packed {
        psp_phase_t  phase;
        logic        mode_rmii;
        logic [4:0]  addr;
        logic        led_en;
        psp_rx_t     rx;
        logic [7:0]  sfd_sh;
        logic [5:0]  div;
        logic        tick;
        logic [1:0]  rxd;
        logic        col_crs_dv;
        logic        crs;
        logic [3:0]  led;
        logic        aw_have;
        logic [7:0]  awaddr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } psp_state_t;

endpackage

// File: shared/psp_stream_if.sv
`timescale 1ns/10ps
`default_nettype none

interface psp_stream_if #(
    parameter int WIDTH = 2
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// File: rtl/psp_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module psp_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    psp_stream_if.snk                       push,
    psp_stream_if.src                       pop,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    // ============================================================
    // Storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    logic             do_push;
    logic             do_pop;

    // Full and empty come straight from the count, never guessed
    assign push.ready = (count_ff != CW'(DEPTH));
    assign pop.valid  = (count_ff != '0);
    assign pop.data   = mem[rd_ptr_ff];
    assign level      = count_ff;
    assign do_push    = push.valid && push.ready;
    assign do_pop     = pop.valid && pop.ready;

    always_ff @(posedge aclk) begin
        if (do_push) begin
            mem[wr_ptr_ff] <= push.data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (do_pop && !do_push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// File: rtl/psp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "psp_defs.svh"

// Notes on behaviour
// R01 - Latch MII/RMII mode at reset release
// R02 - Board floats or pulls mode pin
// R03 - MII: collision drives collision output
// R04 - RMII: CRS_DV while medium non-idle
// R05 - RMII 10M: data zero until SFD
// R06 - 10M half-duplex: no transmit echo
// R07 - MII: carrier drives carrier output
// R08 - Speed indicator active at 100M
// R09 - Link indicator active while link up
// R10 - Activity indicator follows carrier sense
// R11 - Duplex indicator active in full duplex
// R12 - Address bits from five strap pins
// R13 - Indicator pins double as straps
// R14 - Station clocks shared serial management line
// R15 - Straps captured on external reset rise
// R16 - RMII reference clock is 50 MHz
// R17 - Latched straps hold until next release
// R18 - Shared pins undriven during reset
module psp_top
    import psp_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        external_reset_low,
    // Medium side status and receive dibits
    input  wire logic        med_collision,
    input  wire logic        med_carrier,
    input  wire logic        med_link_up,
    input  wire logic        med_speed_indicator,
    input  wire logic        med_full_duplex,
    input  wire logic        med_rx_valid,
    input  wire logic [1:0]  med_rx_dibit,
    input  wire logic        med_rx_echo,
    output logic             med_rx_ready,
    // Collision / mode strap / CRS_DV pin
    input  wire logic        col_mode_in,
    output logic             col_mode_out,
    output logic             col_mode_oe_n,
    // Carrier sense / address bit 4 pin
    input  wire logic        crs_addr4_in,
    output logic             crs_addr4_out,
    output logic             crs_addr4_oe_n,
    // Indicator pins [3]=duplex [2]=activity [1]=link [0]=speed
    input  wire logic [3:0]  ind_in,
    output logic [3:0]       ind_out,
    output logic [3:0]       ind_oe_n,
    output logic [1:0]       rmii_rxd,
    output logic [4:0]       strap_addr,
    output logic             strap_mode_rmii,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int LW = $clog2(FIFO_DEPTH+1);

    // ============================================================
    // Receive buffer
    psp_stream_if #(.WIDTH(2)) rx_push ();
    psp_stream_if #(.WIDTH(2)) rx_pop ();
    logic [LW-1:0] fifo_level;

    psp_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .aclk    (aclk),
        .aresetn (aresetn),
        .push    (rx_push),
        .pop     (rx_pop),
        .level   (fifo_level)
    );

    // ============================================================
    // Register decode helpers
    function automatic logic reg_known(input logic [7:0] a);
        if (a == `PSP_REG_STATUS) begin
            return 1'b1;
        end else if (a == `PSP_REG_CTRL) begin
            return 1'b1;
        end else if (a == `PSP_REG_STRAP) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    psp_state_t cur_ff;
    psp_state_t nxt_cur;
    logic       in_reset;
    logic       rx_take;
    logic       rx_drop;
    logic [7:0] sh_next;
    logic [31:0] status_word;

    // Core reset covers both the bus reset and the external pin
    assign in_reset = !external_reset_low || (cur_ff.phase == PSP_PH_RESET);

    // ============================================================
    // Receive path steering
    always_comb begin
        // R06 - drop transmit echo
        rx_drop = !med_full_duplex && !med_speed_indicator && med_rx_echo;
        if (!cur_ff.mode_rmii || cur_ff.rx == PSP_RX_IDLE || in_reset) begin
            // Nothing is framed here, so dibits are discarded at once
            rx_push.valid = 1'b0;
            med_rx_ready  = 1'b1;
        end else begin
            rx_push.valid = med_rx_valid && !rx_drop;
            med_rx_ready  = rx_push.ready || rx_drop;
        end
        // R05 - zeros until SFD
        rx_push.data = (cur_ff.rx == PSP_RX_HUNT) ? 2'b00 : med_rx_dibit;
        rx_take      = med_rx_valid && med_rx_ready && !rx_drop;
        // Wire order: bit 0 of a dibit goes out first
        sh_next      = {cur_ff.sfd_sh[5:0], med_rx_dibit[0], med_rx_dibit[1]};
        // Drain at the line rate so a slow slot really backs up
        rx_pop.ready = cur_ff.tick;
    end

    always_comb begin
        status_word = '0;
        status_word[`PSP_STAT_ADDR_LSB +: 5] = cur_ff.addr;
        status_word[`PSP_STAT_MODE]          = cur_ff.mode_rmii;
        status_word[`PSP_STAT_LINK]          = med_link_up;
        status_word[`PSP_STAT_SPEED]         = med_speed_indicator;
        status_word[`PSP_STAT_DUPLEX]        = med_full_duplex;
        status_word[`PSP_STAT_CARRIER]       = med_carrier;
        status_word[`PSP_STAT_COLL]          = med_collision;
        status_word[`PSP_STAT_LEVEL_LSB +: LW] = fifo_level;
    end

    // ============================================================
    // Next state
    always_comb begin
        nxt_cur      = cur_ff;
        nxt_cur.tick = 1'b0;

        if (!external_reset_low) begin
            nxt_cur.phase = PSP_PH_RESET;
        end else if (cur_ff.phase == PSP_PH_RESET) begin
            // R01 - mode latched on release
            // R15 - capture on reset rise
            nxt_cur.phase     = PSP_PH_RUN;
            nxt_cur.mode_rmii = col_mode_in;
            // R12 - address from straps
            nxt_cur.addr      = {crs_addr4_in, ind_in[3], ind_in[2], ind_in[1], ind_in[0]};
        end
        // R17 - straps otherwise held

        // Slot divider, one enable pulse per dibit time
        if (cur_ff.div == '0) begin
            nxt_cur.div  = med_speed_indicator ? 6'(`PSP_DIV_100M - 1) : 6'(`PSP_DIV_10M - 1);
            nxt_cur.tick = 1'b1;
        end else begin
            nxt_cur.div = cur_ff.div - 1'b1;
        end

        // Receive framing
        case (cur_ff.rx)
            PSP_RX_IDLE: begin
                if (cur_ff.mode_rmii && med_carrier && !in_reset) begin
                    nxt_cur.rx     = med_speed_indicator ? PSP_RX_PASS : PSP_RX_HUNT;
                    nxt_cur.sfd_sh = '0;
                end
            end
            PSP_RX_HUNT: begin
                if (!med_carrier) begin
                    nxt_cur.rx = PSP_RX_IDLE;
                end else if (rx_take) begin
                    nxt_cur.sfd_sh = sh_next;
                    if (sh_next == `PSP_SFD_PATTERN) begin
                        nxt_cur.rx = PSP_RX_PASS;
                    end
                end
            end
            PSP_RX_PASS: begin
                if (!med_carrier) begin
                    nxt_cur.rx = PSP_RX_IDLE;
                end
            end
            default: begin
                nxt_cur.rx = PSP_RX_IDLE;
            end
        endcase

        if (cur_ff.tick) begin
            nxt_cur.rxd = (rx_pop.valid && cur_ff.mode_rmii) ? rx_pop.data : 2'b00;
        end

        // R03 - collision in MII
        // R04 - CRS_DV in RMII
        nxt_cur.col_crs_dv = cur_ff.mode_rmii ? med_carrier : med_collision;
        // R07 - carrier sense in MII
        nxt_cur.crs        = med_carrier;
        // R08 - speed indicator
        nxt_cur.led[0]     = cur_ff.led_en && med_speed_indicator;
        // R09 - link indicator
        nxt_cur.led[1]     = cur_ff.led_en && med_link_up;
        // R10 - activity indicator
        nxt_cur.led[2]     = cur_ff.led_en && med_carrier;
        // R11 - duplex indicator
        nxt_cur.led[3]     = cur_ff.led_en && med_full_duplex;

        // AXI write: address and data accepted in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_cur.aw_have = 1'b1;
            nxt_cur.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_cur.w_have = 1'b1;
            nxt_cur.wdata  = s_axi_wdata;
            nxt_cur.wstrb  = s_axi_wstrb;
        end
        if (cur_ff.aw_have && cur_ff.w_have && !cur_ff.bvalid) begin
            nxt_cur.aw_have = 1'b0;
            nxt_cur.w_have  = 1'b0;
            nxt_cur.bvalid  = 1'b1;
            nxt_cur.bresp   = reg_known(cur_ff.awaddr) ? `PSP_RESP_OKAY : `PSP_RESP_SLVERR;
            if (cur_ff.awaddr == `PSP_REG_CTRL && cur_ff.wstrb[0]) begin
                nxt_cur.led_en = cur_ff.wdata[`PSP_CTRL_LED_EN];
            end
        end
        if (cur_ff.bvalid && s_axi_bready) begin
            nxt_cur.bvalid = 1'b0;
        end

        // AXI read: one cycle from address to data
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_cur.rvalid = 1'b1;
            nxt_cur.rresp  = reg_known(s_axi_araddr) ? `PSP_RESP_OKAY : `PSP_RESP_SLVERR;
            if (s_axi_araddr == `PSP_REG_STATUS) begin
                nxt_cur.rdata = status_word;
            end else if (s_axi_araddr == `PSP_REG_CTRL) begin
                nxt_cur.rdata = {31'h0, cur_ff.led_en};
            end else if (s_axi_araddr == `PSP_REG_STRAP) begin
                nxt_cur.rdata = {26'h0, cur_ff.mode_rmii, cur_ff.addr};
            end else begin
                nxt_cur.rdata = 32'h0;
            end
        end else if (cur_ff.rvalid && s_axi_rready) begin
            nxt_cur.rvalid = 1'b0;
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_ff <= '{
                phase:      PSP_PH_RESET,
                led_en:     `PSP_CTRL_RESET,
                rx:         PSP_RX_IDLE,
                default:    '0
            };
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ============================================================
    // Pins and bus outputs
    // R13 - shared strap/indicator pins
    // R18 - released during reset
    assign col_mode_oe_n   = in_reset;
    assign crs_addr4_oe_n  = in_reset;
    assign ind_oe_n        = {4{in_reset}};
    assign col_mode_out    = cur_ff.col_crs_dv;
    assign crs_addr4_out   = cur_ff.crs;
    assign ind_out         = cur_ff.led;
    assign rmii_rxd        = cur_ff.rxd;
    assign strap_addr      = cur_ff.addr;
    assign strap_mode_rmii = cur_ff.mode_rmii;

    assign s_axi_awready = !cur_ff.aw_have && !cur_ff.bvalid;
    assign s_axi_wready  = !cur_ff.w_have && !cur_ff.bvalid;
    assign s_axi_bvalid  = cur_ff.bvalid;
    assign s_axi_bresp   = cur_ff.bresp;
    // Reads are held off while an answer waits, so one read at a time
    assign s_axi_arready = !cur_ff.rvalid;
    assign s_axi_rvalid  = cur_ff.rvalid;
    assign s_axi_rdata   = cur_ff.rdata;
    assign s_axi_rresp   = cur_ff.rresp;
endmodule

`default_nettype wire

// File: verif/psp_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module psp_top_assertions (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       external_reset_low,
    input wire logic       med_collision,
    input wire logic       med_carrier,
    input wire logic       med_link_up,
    input wire logic       med_speed_indicator,
    input wire logic       med_full_duplex,
    input wire logic       col_mode_in,
    input wire logic       col_mode_out,
    input wire logic       col_mode_oe_n,
    input wire logic       crs_addr4_in,
    input wire logic       crs_addr4_out,
    input wire logic       crs_addr4_oe_n,
    input wire logic [3:0] ind_in,
    input wire logic [3:0] ind_out,
    input wire logic [3:0] ind_oe_n,
    input wire logic [4:0] strap_addr,
    input wire logic       strap_mode_rmii
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ==========
    // Strap sequences
    sequence s_release;
        $rose(external_reset_low);
    endsequence
    // Two running cycles in a row, so a fresh latch is not taken for drift
    sequence s_running;
        external_reset_low && $past(external_reset_low) && $past(aresetn);
    endsequence
    // ==========
    // Assertions
    AST_PINS_RELEASED: assert property (
        !external_reset_low |-> col_mode_oe_n && crs_addr4_oe_n && (&ind_oe_n))
        else $error("Shared pins driven during external reset");
    AST_MODE_LATCH: assert property (
        s_release |=> strap_mode_rmii == $past(col_mode_in))
        else $error("Mode strap not latched");
    AST_ADDR_LATCH: assert property (
        s_release |=> strap_addr == $past({crs_addr4_in, ind_in}))
        else $error("Address straps not latched");
    AST_STRAP_HOLD: assert property (
        s_running |=> $stable(strap_addr) && $stable(strap_mode_rmii))
        else $error("Latched straps changed");
    AST_COL_MII: assert property (
        !strap_mode_rmii && !col_mode_oe_n |=> col_mode_oe_n || col_mode_out == $past(med_collision))
        else $error("Collision output wrong");
    AST_CRS_DV: assert property (
        strap_mode_rmii && !col_mode_oe_n |=> col_mode_oe_n || col_mode_out == $past(med_carrier))
        else $error("Carrier valid output wrong");
    AST_CRS_MII: assert property (
        !strap_mode_rmii && !crs_addr4_oe_n |=> crs_addr4_oe_n || crs_addr4_out == $past(med_carrier))
        else $error("Carrier output wrong");
    AST_IND_CAUSE: assert property (
        (ind_out & ~ind_oe_n & ~$past({med_full_duplex, med_carrier, med_link_up, med_speed_indicator})) == 4'h0)
        else $error("Indicator lit without cause");
endmodule

bind psp_top psp_top_assertions u_psp_top_assertions (
    .aclk, .aresetn, .external_reset_low, .med_collision, .med_carrier, .med_link_up,
    .med_speed_indicator, .med_full_duplex, .col_mode_in, .col_mode_out, .col_mode_oe_n,
    .crs_addr4_in, .crs_addr4_out, .crs_addr4_oe_n, .ind_in, .ind_out, .ind_oe_n,
    .strap_addr, .strap_mode_rmii);

`default_nettype wire

// File: verif/psp_mac_model.sv
`timescale 1ns/10ps
`default_nettype none

// Board strap resistors plus a controller watching the receive pins
module psp_mac_model (
    input  wire logic       aclk,
    input  wire logic       clr,
    input  wire logic       pull_mode,
    input  wire logic [4:0] pull_addr,
    input  wire logic       col_mode_out,
    input  wire logic       col_mode_oe_n,
    input  wire logic       crs_addr4_out,
    input  wire logic       crs_addr4_oe_n,
    input  wire logic [3:0] ind_out,
    input  wire logic [3:0] ind_oe_n,
    input  wire logic [1:0] rmii_rxd,
    output logic            col_mode_in,
    output logic            crs_addr4_in,
    output logic [3:0]      ind_in,
    output logic [3:0]      seen
);
    // resistor level only while released
    // A released pin is modelled as its pull_mode or pull_addr level, never as a held value
    assign col_mode_in  = col_mode_oe_n ? pull_mode : col_mode_out;
    assign crs_addr4_in = crs_addr4_oe_n ? pull_addr[4] : crs_addr4_out;
    assign ind_in       = (ind_oe_n & pull_addr[3:0]) | (~ind_oe_n & ind_out);
    // Remember every dibit value shown on the data pins
    always_ff @(posedge aclk) begin
        if (clr) begin
            seen <= 4'h0;
        end else begin
            seen[rmii_rxd] <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// File: verif/tb_psp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "psp_defs.svh"

module tb_psp_top;
    logic aclk = 1'b0, aresetn = 1'b0, external_reset_low = 1'b1, clr = 1'b0;
    logic med_collision = 1'b0, med_carrier = 1'b0, med_link_up = 1'b0, med_speed_indicator = 1'b0;
    logic med_full_duplex = 1'b0, med_rx_valid = 1'b0, med_rx_echo = 1'b0, pull_mode = 1'b1;
    logic [1:0] med_rx_dibit = 2'h0;
    logic [4:0] pull_addr = 5'h15;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic med_rx_ready, col_mode_in, col_mode_out, col_mode_oe_n, strap_mode_rmii;
    logic crs_addr4_in, crs_addr4_out, crs_addr4_oe_n;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0] ind_in, ind_out, ind_oe_n, seen;
    logic [1:0] rmii_rxd, s_axi_bresp, s_axi_rresp, rsp;
    logic [4:0] strap_addr;
    logic [31:0] s_axi_rdata, rd;
    int error_cnt = 0;
    int num_checks = 0;

    psp_top u_psp_top (.aclk, .aresetn, .external_reset_low, .med_collision, .med_carrier,
        .med_link_up, .med_speed_indicator, .med_full_duplex, .med_rx_valid, .med_rx_dibit, .med_rx_echo,
        .med_rx_ready, .col_mode_in, .col_mode_out, .col_mode_oe_n, .crs_addr4_in, .crs_addr4_out,
        .crs_addr4_oe_n, .ind_in, .ind_out, .ind_oe_n, .rmii_rxd, .strap_addr, .strap_mode_rmii,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    psp_mac_model u_psp_mac_model (.aclk, .clr, .pull_mode, .pull_addr, .col_mode_out,
        .col_mode_oe_n, .crs_addr4_out, .crs_addr4_oe_n, .ind_out, .ind_oe_n, .rmii_rxd,
        .col_mode_in, .crs_addr4_in, .ind_in, .seen);

    // line slot rate is divided from this clock
    always #2 aclk = ~aclk;

    // ==========
    // Common tasks
    task finish_test;
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task tmo(input string n);
        chk(n, 32'h0, 32'h1);
        finish_test();
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Ends one edge after release, so the next call never re-drives in the same step
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 100 && !s_axi_bvalid; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (i == 100) tmo("write wait");
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task axi_rd(input logic [7:0] a);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 100 && !s_axi_rvalid; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (i == 100) tmo("read wait");
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Valid stays up between dibits; the caller drops it once
    task push(input logic [1:0] d, input logic e);
        int i;
        med_rx_valid <= 1'b1;
        med_rx_dibit <= d;
        med_rx_echo <= e;
        for (i = 0; i < 200; i++) begin
            @(posedge aclk);
            if (med_rx_ready) break;
        end
        if (i == 200) tmo("rx wait");
    endtask

    // ==========
    // Scenarios
    task t_straps;
        chk("mode", strap_mode_rmii, 1'b1);
        chk("addr", strap_addr, 5'h15);
        chk("oe run", {col_mode_oe_n, crs_addr4_oe_n, ind_oe_n}, 6'h00);
        pull_addr <= 5'h0a;
        pull_mode <= 1'b0;
        med_link_up <= 1'b1;
        cyc(5);
        chk("addr held", {strap_mode_rmii, strap_addr}, 6'h35);
        med_link_up <= 1'b0;
        axi_rd(`PSP_REG_STRAP);
        chk("strap reg", rd, 32'h35);
    endtask
    task t_ind;
        logic [4:0] v;
        for (v = 0; v < 16; v++) begin
            {med_full_duplex, med_carrier, med_link_up, med_speed_indicator} <= v[3:0];
            cyc(3);
            chk("ind", ind_out, v[3:0]);
            chk("crs_dv", col_mode_out, v[2]);
        end
        axi_wr(`PSP_REG_CTRL, 32'h0);
        cyc(2);
        chk("ind off", {rsp, ind_out}, 6'h00);
        axi_wr(`PSP_REG_CTRL, 32'h1);
        axi_rd(`PSP_REG_STATUS);
        chk("status", rd, 32'h3f5);
        chk("status resp", rsp, `PSP_RESP_OKAY);
        axi_rd(8'h0c);
        chk("unmapped rd", rd, 32'h0);
        chk("unmapped rd resp", rsp, `PSP_RESP_SLVERR);
        axi_wr(8'h10, 32'hffffffff);
        chk("unmapped wr", rsp, `PSP_RESP_SLVERR);
        {med_full_duplex, med_carrier, med_link_up, med_speed_indicator} <= 4'h0;
        cyc(3);
    endtask
    // Preamble then echoed ones: a design that shifts echoes would find the delimiter
    task t_sfd10;
        med_carrier <= 1'b1;
        clr <= 1'b1;
        cyc(2);
        clr <= 1'b0;
        repeat (6) push(2'h1, 1'b0);
        repeat (2) push(2'h3, 1'b1);
        med_rx_valid <= 1'b0;
        cyc(450);
        chk("before sfd", seen, 4'h1);
        push(2'h3, 1'b0);
        repeat (2) push(2'h2, 1'b0);
        med_rx_valid <= 1'b0;
        cyc(300);
        chk("after sfd", seen[2], 1'b1);
        // Carrier must really fall so the frame ends before the next one
        med_carrier <= 1'b0;
        cyc(3);
    endtask
    task t_fifo100;
        int n;
        n = 0;
        med_speed_indicator <= 1'b1;
        med_carrier <= 1'b1;
        clr <= 1'b1;
        cyc(2);
        clr <= 1'b0;
        med_rx_valid <= 1'b1;
        med_rx_dibit <= 2'h3;
        repeat (60) begin
            @(posedge aclk);
            if (med_rx_ready !== 1'b1) n++;
        end
        med_rx_valid <= 1'b0;
        chk("refused", n > 0, 1'b1);
        cyc(120);
        axi_rd(`PSP_REG_STATUS);
        chk("drained", {seen[3], rd[20:16]}, 6'h20);
        med_carrier <= 1'b0;
        med_speed_indicator <= 1'b0;
    endtask
    task t_mii;
        external_reset_low <= 1'b0;
        cyc(5);
        chk("oe ext", {col_mode_oe_n, crs_addr4_oe_n, ind_oe_n}, 6'h3f);
        external_reset_low <= 1'b1;
        cyc(3);
        chk("mii latch", {strap_mode_rmii, strap_addr}, 6'h0a);
        med_collision <= 1'b1;
        med_carrier <= 1'b1;
        cyc(3);
        chk("col on", {col_mode_out, crs_addr4_out}, 2'h3);
        med_collision <= 1'b0;
        cyc(3);
        chk("col off", {col_mode_out, crs_addr4_out}, 2'h1);
        med_carrier <= 1'b0;
    endtask

    initial begin
        cyc(10);
        chk("oe reset", {col_mode_oe_n, crs_addr4_oe_n, ind_oe_n}, 6'h3f);
        cyc(10);
        aresetn <= 1'b1;
        cyc(3);
        t_straps();
        t_ind();
        t_sfd10();
        t_fifo100();
        t_mii();
        finish_test();
    end
endmodule

`default_nettype wire
